// ### rtl/pcg_pkg.sv
/*
  constants and types for the peripheral clock gating block: register offsets,
  reset values, writable masks, field positions and gated clock indices.
  assumes a 32-bit apb register bus and one system clock.
*/
package pcg_pkg;
  // bus geometry
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned STRB_W = DATA_W / 8;
  // register byte offsets
  localparam logic [ADDR_W-1:0] AHB_GATE_OFS = 12'h014;
  localparam logic [ADDR_W-1:0] APB2_GATE_OFS = 12'h018;
  // reset values
  localparam logic [DATA_W-1:0] AHB_GATE_RST = 32'h0000_0014;
  localparam logic [DATA_W-1:0] APB2_GATE_RST = 32'h0000_0000;
  // implemented bits, all others are reserved and read zero
  localparam logic [DATA_W-1:0] AHB_GATE_MASK = 32'h0000_1157;
  localparam logic [DATA_W-1:0] APB2_GATE_MASK = 32'h0038_7E7D;
  // field positions in the ahb gate register
  localparam int unsigned AHB_USB_BIT = 12;
  localparam int unsigned AHB_EXMC_BIT = 8;
  localparam int unsigned AHB_CRC_BIT = 6;
  localparam int unsigned AHB_FLASH_BIT = 4;
  localparam int unsigned AHB_SRAM_BIT = 2;
  localparam int unsigned AHB_DMA1_BIT = 1;
  localparam int unsigned AHB_DMA0_BIT = 0;
  // field positions in the apb2 gate register
  localparam int unsigned APB2_TIM10_BIT = 21;
  localparam int unsigned APB2_TIM9_BIT = 20;
  localparam int unsigned APB2_TIM8_BIT = 19;
  localparam int unsigned APB2_SER0_BIT = 14;
  localparam int unsigned APB2_TIM7_BIT = 13;
  localparam int unsigned APB2_SPI0_BIT = 12;
  localparam int unsigned APB2_TIM0_BIT = 11;
  localparam int unsigned APB2_ADC1_BIT = 10;
  localparam int unsigned APB2_ADC0_BIT = 9;
  localparam int unsigned APB2_PORTE_BIT = 6;
  localparam int unsigned APB2_PORTA_BIT = 2;
  localparam int unsigned APB2_AFIO_BIT = 0;
  // number of gated clock outputs
  localparam int unsigned NUM_CLK = 22;
  // gate enables, packed msb first; bit index equals gated clock index
  typedef struct packed {
    logic usb_fullspeed_gate;     // 21
    logic ext_memory_ctrl_gate;   // 20
    logic checksum_unit_gate;     // 19
    logic flash_ctrl_run;         // 18, sleep aware
    logic sram_if_run;            // 17, sleep aware
    logic dma_second_gate;        // 16
    logic dma_first_gate;         // 15
    logic timer_ten_gate;         // 14
    logic timer_nine_gate;        // 13
    logic timer_eight_gate;       // 12
    logic serial_port_zero_gate;  // 11
    logic timer_seven_gate;       // 10
    logic spi_port_zero_gate;     // 9
    logic timer_zero_gate;        // 8
    logic converter_one_gate;     // 7
    logic converter_zero_gate;    // 6
    logic [4:0] port_gate;        // 5..1, port e down to port a
    logic alt_function_io_gate;   // 0
  } pcg_gate_s;
  // indices into the gated clock vector
  localparam int unsigned CLK_USB = 21;
  localparam int unsigned CLK_FLASH = 18;
  localparam int unsigned CLK_SRAM = 17;
  localparam int unsigned CLK_TIM10 = 14;
  localparam int unsigned CLK_TIM8 = 12;
  localparam int unsigned CLK_PORTA = 1;
  localparam int unsigned CLK_AFIO = 0;
endpackage

// ### rtl/pcg_top.sv
/*
  peripheral clock gating: two software gate registers on apb and one
  glitch free clock gate per peripheral clock.
  assumes CLOCK is the bus clock that feeds every gated peripheral, SLEEP_MODE
  comes from the power controller on the same clock, and the apb master
  follows the usual setup then access sequence.
*/
// Design decision made here: the APB register port.
// Notes on behaviour
// - ahb bit 12 gates usb full-speed clock
// - ahb bit 8 gates external memory clock
// - ahb bit 6 gates checksum unit clock
// - ahb bit 4 keeps flash clock in sleep
// - ahb bit 2 keeps sram clock in sleep
// - ahb bits 1, 0 gate both dma clocks
// - apb2 gate register resets to all zero
// - apb2 bits 21..19 gate timers ten..eight
// - apb2 bit 14 gates serial port zero
// - apb2 bit 13 gates timer seven
// - apb2 bit 12 gates spi port zero
// - apb2 bit 11 gates timer zero
// - apb2 bits 10, 9 gate both converters
// - apb2 bits 6..2 gate ports e..a
// - apb2 bit 0 gates alternate function clock
// - gate bits change only by software writes
module pcg_top #(
  parameter int unsigned N_CLK = pcg_pkg::NUM_CLK
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic SLEEP_MODE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [pcg_pkg::ADDR_W-1:0] PADDR,
  input wire logic [pcg_pkg::DATA_W-1:0] PWDATA,
  input wire logic [pcg_pkg::STRB_W-1:0] PSTRB,
  output logic [pcg_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic [N_CLK-1:0] GATED_CLK,
  output logic [N_CLK-1:0] GATE_STATE
);

  // merge write data into a register under byte strobes and a writable mask
  function automatic logic [pcg_pkg::DATA_W-1:0] merge_write(
    input logic [pcg_pkg::DATA_W-1:0] old_val,
    input logic [pcg_pkg::DATA_W-1:0] wdata,
    input logic [pcg_pkg::STRB_W-1:0] strb,
    input logic [pcg_pkg::DATA_W-1:0] mask
  );
    logic [pcg_pkg::DATA_W-1:0] lane;
    lane = '0;
    for (int b = 0; b < pcg_pkg::STRB_W; b++) begin
      lane[b*8 +: 8] = {8{strb[b]}};
    end
    return (old_val & ~(lane & mask)) | (wdata & lane & mask);
  endfunction

  // software gate registers
  logic [pcg_pkg::DATA_W-1:0] ahb_gate_reg;   // ahb clock gate register
  logic [pcg_pkg::DATA_W-1:0] apb2_gate_reg;  // apb2 clock gate register
  logic [pcg_pkg::DATA_W-1:0] rdata_reg;      // read data held for access phase
  logic slverr_reg;                           // error held for access phase

  // bus decode
  logic setup_phase;   // first cycle of a transfer
  logic access_done;   // access phase completing this edge
  logic hit_ahb;       // address selects the ahb gate register
  logic hit_apb2;      // address selects the apb2 gate register
  logic wr_ahb;        // write into the ahb gate register
  logic wr_apb2;       // write into the apb2 gate register

  assign setup_phase = PSEL && !PENABLE;
  assign access_done = PSEL && PENABLE && PREADY;
  assign hit_ahb = (PADDR == pcg_pkg::AHB_GATE_OFS);
  assign hit_apb2 = (PADDR == pcg_pkg::APB2_GATE_OFS);
  assign wr_ahb = access_done && PWRITE && hit_ahb;
  assign wr_apb2 = access_done && PWRITE && hit_apb2;

  // zero wait state slave, answers in the first access cycle
  assign PREADY = 1'b1;

  // read data and error, captured during setup so they come from flops
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else if (setup_phase) begin
      // reserved bits read as zero
      if (hit_ahb) begin
        rdata_reg <= ahb_gate_reg & pcg_pkg::AHB_GATE_MASK;
      end else if (hit_apb2) begin
        rdata_reg <= apb2_gate_reg & pcg_pkg::APB2_GATE_MASK;
      end else begin
        rdata_reg <= '0;
      end
      // unmapped address answers with an error
      slverr_reg <= !(hit_ahb || hit_apb2);
    end
  end

  // error is flagged only in the access phase
  assign PRDATA = rdata_reg;
  assign PSLVERR = slverr_reg && PSEL && PENABLE;

  // ahb gate register, only software moves it
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ahb_gate_reg <= pcg_pkg::AHB_GATE_RST;
    end else if (wr_ahb) begin
      // reserved bits are masked off, whatever software writes there
      ahb_gate_reg <= merge_write(ahb_gate_reg, PWDATA, PSTRB,
                                  pcg_pkg::AHB_GATE_MASK);
    end
  end

  // apb2 gate register, all clocks stopped after reset
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      apb2_gate_reg <= pcg_pkg::APB2_GATE_RST;
    end else if (wr_apb2) begin
      apb2_gate_reg <= merge_write(apb2_gate_reg, PWDATA, PSTRB,
                                   pcg_pkg::APB2_GATE_MASK);
    end
  end

  // map register fields onto per clock enables
  pcg_pkg::pcg_gate_s gate_en;   // enables in clock index order
  logic [N_CLK-1:0] en_vec;      // same enables as a flat vector

  always_comb begin
    gate_en.usb_fullspeed_gate = ahb_gate_reg[pcg_pkg::AHB_USB_BIT];
    gate_en.ext_memory_ctrl_gate = ahb_gate_reg[pcg_pkg::AHB_EXMC_BIT];
    gate_en.checksum_unit_gate = ahb_gate_reg[pcg_pkg::AHB_CRC_BIT];
    // flash and sram run when awake, and in sleep only if kept
    gate_en.flash_ctrl_run = !SLEEP_MODE || ahb_gate_reg[pcg_pkg::AHB_FLASH_BIT];
    gate_en.sram_if_run = !SLEEP_MODE || ahb_gate_reg[pcg_pkg::AHB_SRAM_BIT];
    gate_en.dma_second_gate = ahb_gate_reg[pcg_pkg::AHB_DMA1_BIT];
    gate_en.dma_first_gate = ahb_gate_reg[pcg_pkg::AHB_DMA0_BIT];
    gate_en.timer_ten_gate = apb2_gate_reg[pcg_pkg::APB2_TIM10_BIT];
    gate_en.timer_nine_gate = apb2_gate_reg[pcg_pkg::APB2_TIM9_BIT];
    gate_en.timer_eight_gate = apb2_gate_reg[pcg_pkg::APB2_TIM8_BIT];
    gate_en.serial_port_zero_gate = apb2_gate_reg[pcg_pkg::APB2_SER0_BIT];
    gate_en.timer_seven_gate = apb2_gate_reg[pcg_pkg::APB2_TIM7_BIT];
    gate_en.spi_port_zero_gate = apb2_gate_reg[pcg_pkg::APB2_SPI0_BIT];
    gate_en.timer_zero_gate = apb2_gate_reg[pcg_pkg::APB2_TIM0_BIT];
    gate_en.converter_one_gate = apb2_gate_reg[pcg_pkg::APB2_ADC1_BIT];
    gate_en.converter_zero_gate = apb2_gate_reg[pcg_pkg::APB2_ADC0_BIT];
    // ports e down to a, in bit order
    gate_en.port_gate = apb2_gate_reg[pcg_pkg::APB2_PORTE_BIT:pcg_pkg::APB2_PORTA_BIT];
    gate_en.alt_function_io_gate = apb2_gate_reg[pcg_pkg::APB2_AFIO_BIT];
  end

  assign en_vec = N_CLK'(gate_en);

  // registered copy of the enables for status, one cycle behind
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      GATE_STATE <= '0;
    end else begin
      GATE_STATE <= en_vec;
    end
  end

  // one latch based gate per clock
  logic [N_CLK-1:0] en_lat;   // enable held while the clock is high

  generate
    for (genvar i = 0; i < N_CLK; i++) begin : g_gate
      // latch is open only while the clock is low, so an enable change
      // never cuts a high pulse short or adds a runt one
      always_latch begin
        if (!CLOCK) begin
          en_lat[i] = en_vec[i];
        end
      end
      assign GATED_CLK[i] = CLOCK && en_lat[i];
    end
  endgenerate

  // helper for assertions: full word write into a register
  logic full_strb;   // every byte lane written
  assign full_strb = &PSTRB;

  // shadow of the last word written to the apb2 register, for readback
  logic [pcg_pkg::DATA_W-1:0] apb2_shadow_reg; // last word written, full or partial
  logic apb2_shadow_ok_reg; // shadow still matches the register

  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      apb2_shadow_reg <= pcg_pkg::APB2_GATE_RST;
      apb2_shadow_ok_reg <= 1'b1; // register comes out of reset known
    end else if (wr_apb2) begin
      // a partial write leaves lanes the shadow does not know
      apb2_shadow_reg <= PWDATA;
      apb2_shadow_ok_reg <= full_strb;
    end
  end

  // assertions

  property p_apb2_reset;
    @(posedge CLOCK) $fell(SYS_RST) |-> (apb2_gate_reg == pcg_pkg::APB2_GATE_RST)
      && (GATE_STATE[pcg_pkg::CLK_TIM10:pcg_pkg::CLK_AFIO] == '0);
  endproperty
  a_apb2_reset: assert property (p_apb2_reset)
    else $error("apb2 gate register not zero after reset");

  property p_hold;
    @(posedge CLOCK) disable iff (SYS_RST)
      !(wr_ahb || wr_apb2) |=> $stable(ahb_gate_reg) && $stable(apb2_gate_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("gate register changed without a write");

  property p_readback;
    @(posedge CLOCK) disable iff (SYS_RST)
      PSEL && PENABLE && !PWRITE && hit_apb2 && apb2_shadow_ok_reg
      |-> PRDATA == (apb2_shadow_reg & pcg_pkg::APB2_GATE_MASK);
  endproperty
  a_readback: assert property (p_readback)
    else $error("apb2 gate read back differs from written value");

  property p_usb;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_ahb && full_strb |=> en_vec[pcg_pkg::CLK_USB] == $past(PWDATA[pcg_pkg::AHB_USB_BIT]);
  endproperty
  a_usb: assert property (p_usb)
    else $error("usb clock gate does not follow its bit");

  property p_flash_sleep;
    @(posedge CLOCK) disable iff (SYS_RST)
      SLEEP_MODE && !ahb_gate_reg[pcg_pkg::AHB_FLASH_BIT] |-> !en_vec[pcg_pkg::CLK_FLASH];
  endproperty
  a_flash_sleep: assert property (p_flash_sleep)
    else $error("flash clock runs in sleep without keep bit");

  property p_sram_awake;
    @(posedge CLOCK) disable iff (SYS_RST)
      !SLEEP_MODE |-> en_vec[pcg_pkg::CLK_SRAM];
  endproperty
  a_sram_awake: assert property (p_sram_awake)
    else $error("sram clock stopped while awake");

  property p_timer8;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> en_vec[pcg_pkg::CLK_TIM8] == $past(PWDATA[pcg_pkg::APB2_TIM8_BIT]);
  endproperty
  a_timer8: assert property (p_timer8)
    else $error("timer eight gate does not follow bit 19");

  property p_port_a;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> ##1 GATE_STATE[pcg_pkg::CLK_PORTA] == $past(PWDATA[pcg_pkg::APB2_PORTA_BIT], 2);
  endproperty
  a_port_a: assert property (p_port_a)
    else $error("port a gate does not follow bit 2");

  property p_afio;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> en_vec[pcg_pkg::CLK_AFIO] == $past(PWDATA[pcg_pkg::APB2_AFIO_BIT]);
  endproperty
  a_afio: assert property (p_afio)
    else $error("alternate function gate does not follow bit 0");

  // enables move only after rising edges, so the value seen at the previous
  // falling edge is the one the latch held through the high phase
  property p_gate_high;
    @(negedge CLOCK) disable iff (SYS_RST)
      GATED_CLK == $past(en_vec);
  endproperty
  a_gate_high: assert property (p_gate_high)
    else $error("gated clock high phase does not match enable");

  property p_ext_mem;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_ahb && full_strb
      |=> gate_en.ext_memory_ctrl_gate == $past(PWDATA[pcg_pkg::AHB_EXMC_BIT]);
  endproperty
  a_ext_mem: assert property (p_ext_mem)
    else $error("external memory gate does not follow its bit");

  property p_checksum;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_ahb && full_strb
      |=> gate_en.checksum_unit_gate == $past(PWDATA[pcg_pkg::AHB_CRC_BIT]);
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum unit gate does not follow its bit");

  property p_dma;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_ahb && full_strb
      |=> gate_en.dma_second_gate == $past(PWDATA[pcg_pkg::AHB_DMA1_BIT])
      && gate_en.dma_first_gate == $past(PWDATA[pcg_pkg::AHB_DMA0_BIT]);
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma clock gates do not follow their bits");

  property p_serial;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> gate_en.serial_port_zero_gate == $past(PWDATA[pcg_pkg::APB2_SER0_BIT]);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial port gate does not follow its bit");

  property p_timer7;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> gate_en.timer_seven_gate == $past(PWDATA[pcg_pkg::APB2_TIM7_BIT]);
  endproperty
  a_timer7: assert property (p_timer7)
    else $error("timer seven gate does not follow its bit");

  property p_spi;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> gate_en.spi_port_zero_gate == $past(PWDATA[pcg_pkg::APB2_SPI0_BIT]);
  endproperty
  a_spi: assert property (p_spi)
    else $error("spi port gate does not follow its bit");

  property p_timer0;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> gate_en.timer_zero_gate == $past(PWDATA[pcg_pkg::APB2_TIM0_BIT]);
  endproperty
  a_timer0: assert property (p_timer0)
    else $error("timer zero gate does not follow its bit");

  property p_converters;
    @(posedge CLOCK) disable iff (SYS_RST)
      wr_apb2 && full_strb
      |=> gate_en.converter_one_gate == $past(PWDATA[pcg_pkg::APB2_ADC1_BIT])
      && gate_en.converter_zero_gate == $past(PWDATA[pcg_pkg::APB2_ADC0_BIT]);
  endproperty
  a_converters: assert property (p_converters)
    else $error("converter gates do not follow their bits");

  property p_sram_sleep;
    @(posedge CLOCK) disable iff (SYS_RST)
      SLEEP_MODE && !ahb_gate_reg[pcg_pkg::AHB_SRAM_BIT] |-> !en_vec[pcg_pkg::CLK_SRAM];
  endproperty
  a_sram_sleep: assert property (p_sram_sleep)
    else $error("sram clock runs in sleep without keep bit");

  property p_flash_keep;
    @(posedge CLOCK) disable iff (SYS_RST)
      ahb_gate_reg[pcg_pkg::AHB_FLASH_BIT] |-> en_vec[pcg_pkg::CLK_FLASH];
  endproperty
  a_flash_keep: assert property (p_flash_keep)
    else $error("flash clock stopped although keep bit is set");

endmodule

// ### tb/peripheral_clock_gating_tb.sv
/*
  self-checking bench for the peripheral clock gating block: apb register
  traffic, gate state and gated clock checks, sleep handling, unmapped access.
  assumes pcg_pkg and pcg_top are compiled first and a zero wait state slave.
*/
module peripheral_clock_gating_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, sys_rst, sleep_mode, psel, penable, pwrite; // bench drives
  logic [pcg_pkg::ADDR_W-1:0] paddr; // byte address
  logic [pcg_pkg::DATA_W-1:0] pwdata, prdata; // bus data
  logic [pcg_pkg::STRB_W-1:0] pstrb; // byte lanes
  logic pready, pslverr; // slave answer
  logic [pcg_pkg::NUM_CLK-1:0] gated_clk, gate_state; // gate outputs
  logic [32:0] exp_q[$]; // expected error and data per transfer
  logic [31:0] ahb_m, apb2_m, v; // register shadows, scratch
  int n_errors, num_checks, i; // counters
  localparam logic [11:0] AHB = pcg_pkg::AHB_GATE_OFS;
  localparam logic [11:0] APB2 = pcg_pkg::APB2_GATE_OFS;

  pcg_top dut (.CLOCK(clock), .SYS_RST(sys_rst), .SLEEP_MODE(sleep_mode), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .GATED_CLK(gated_clk),
    .GATE_STATE(gate_state));

  // 125 mhz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // one comparison, mismatch reported at once
  task check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // counts, verdict, end of run
  task give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // expected enables from the shadows and sleep input
  function automatic logic [21:0] exp_gate();
    exp_gate = {ahb_m[12], ahb_m[8], ahb_m[6], !sleep_mode | ahb_m[4], !sleep_mode | ahb_m[2],
      ahb_m[1], ahb_m[0], apb2_m[21:19], apb2_m[14:9], apb2_m[6:2], apb2_m[0]};
  endfunction

  // one apb transfer; notes the expected answer, updates shadows on writes
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic [31:0] lm;
    logic bad;
    lm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    bad = (a !== AHB) && (a !== APB2);
    if (wr || bad) begin
      exp_q.push_back({bad, 32'h0});
    end else begin
      exp_q.push_back({1'b0, (a == AHB) ? ahb_m : apb2_m});
    end
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= wr ? s : 4'h0;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // wait for the answer, bounded
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
    // lanes with strobe low keep old bits, reserved bits dropped
    if (wr && a == AHB) ahb_m = (ahb_m & ~lm) | (d & lm & pcg_pkg::AHB_GATE_MASK);
    if (wr && a == APB2) apb2_m = (apb2_m & ~lm) | (d & lm & pcg_pkg::APB2_GATE_MASK);
  endtask

  // settle, then gate state per bit and gated clocks in both phases
  task gate_chk;
    logic [21:0] e;
    repeat (3) @(posedge clock);
    #2;
    e = exp_gate();
    for (int k = 0; k < 22; k++) begin
      check(gate_state[k], e[k]);
    end
    check(gated_clk, e);
    @(negedge clock);
    #2;
    check(gated_clk, 22'h0);
  endtask

  // monitor: oldest note against each completed transfer
  initial begin
    forever begin
      @(posedge clock);
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
        if (exp_q.size() == 0) begin
          n_errors++;
        end else begin
          check({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
        end
      end
    end
  end

  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    give_verdict;
  end

  // main sequence
  initial begin
    {sys_rst, sleep_mode, psel, penable, pwrite} = 5'b10000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    v = $urandom(74008);
    ahb_m = pcg_pkg::AHB_GATE_RST;
    apb2_m = pcg_pkg::APB2_GATE_RST;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values
    apb(1'b0, AHB, 32'h0, 4'h0);
    apb(1'b0, APB2, 32'h0, 4'h0);
    gate_chk;
    $display("test reset values done");
    // walking one through every bit, reserved ones must read zero
    for (i = 0; i < 32; i++) begin
      apb(1'b1, AHB, 32'h1 << i, 4'hF);
      apb(1'b1, APB2, 32'h1 << i, 4'hF);
      apb(1'b0, AHB, 32'h0, 4'h0);
      apb(1'b0, APB2, 32'h0, 4'h0);
      gate_chk;
    end
    $display("test walking bits done");
    // random data and strobes, reserved bits kept at reset value
    for (i = 0; i < 40; i++) begin
      v = $urandom & (i[0] ? pcg_pkg::AHB_GATE_MASK : pcg_pkg::APB2_GATE_MASK);
      apb(1'b1, i[0] ? AHB : APB2, v, 4'($urandom));
      apb(1'b0, i[0] ? AHB : APB2, 32'h0, 4'h0);
      sleep_mode <= 1'($urandom);
      gate_chk;
    end
    $display("test random strobes done");
    // sleep with every pair of keep bits
    for (i = 0; i < 4; i++) begin
      apb(1'b1, AHB, (ahb_m & ~32'h14) | (i[1] << 4) | (i[0] << 2), 4'hF);
      sleep_mode <= 1'b1;
      gate_chk;
      @(posedge clock);
      sleep_mode <= 1'b0;
      gate_chk;
    end
    $display("test sleep keep done");
    // unmapped addresses answer with error and change nothing
    apb(1'b1, 12'h01C, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, 12'h01C, 32'h0, 4'h0);
    apb(1'b1, 12'h010, 32'hFFFF_FFFF, 4'hF);
    apb(1'b0, AHB, 32'h0, 4'h0);
    apb(1'b0, APB2, 32'h0, 4'h0);
    $display("test unmapped done");
    // long idle with sleep toggling, bits must hold
    for (i = 0; i < 20; i++) begin
      repeat (10) @(posedge clock);
      sleep_mode <= ~sleep_mode;
    end
    apb(1'b0, AHB, 32'h0, 4'h0);
    apb(1'b0, APB2, 32'h0, 4'h0);
    gate_chk;
    $display("test hold done");
    // second reset in mid run
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    ahb_m = pcg_pkg::AHB_GATE_RST;
    apb2_m = pcg_pkg::APB2_GATE_RST;
    sys_rst <= 1'b0;
    apb(1'b0, AHB, 32'h0, 4'h0);
    apb(1'b0, APB2, 32'h0, 4'h0);
    gate_chk;
    $display("test second reset done");
    give_verdict;
  end
endmodule
